// file: bmoc_consts.svh
`ifndef BMOC_CONSTS_SVH
`define BMOC_CONSTS_SVH

// Octet field positions, common to both octet types
`define BMOC_TYPE_BIT     7
// Type 0 octet fields
`define BMOC_BIF          6:5
`define BMOC_DSGS         4:3
`define BMOC_HOBS         2:1
`define BMOC_ETSS         0
// Type 1 octet fields
`define BMOC_RSVD_BIT     6
`define BMOC_MPAF         5:0
`define BMOC_PR           5:4
`define BMOC_PCM          3:2
`define BMOC_PCC          1:0

// Bus identification codes
`define BMOC_BIF_UNK      2'h0
`define BMOC_BIF_A        2'h1
`define BMOC_BIF_B        2'h2
// Slot generator and page reservation codes
`define BMOC_DSG_NOT      2'h0
`define BMOC_DSG_PRES     2'h3
`define BMOC_PR_NOT       2'h0
`define BMOC_PR_RES       2'h3
// Page counter control codes
`define BMOC_PCC_RESET    2'h1
`define BMOC_PCC_INCR     2'h2

// Register byte offsets
`define BMOC_OFS_CTRL     4'h0
`define BMOC_OFS_TXCFG    4'h4
`define BMOC_OFS_STATUS   4'h8

// Control register bits
`define BMOC_CTRL_HOB     0
`define BMOC_CTRL_BUSB    1
`define BMOC_CTRL_DSGN    2
`define BMOC_CTRL_OWNDSG  3
`define BMOC_CTRL_OWNHOB  4
`define BMOC_CTRL_OWNETS  5
`define BMOC_CTRL_W       6
`define BMOC_CTRL_RST     6'h00

// Transmit configuration register fields
`define BMOC_TX_DSGS      1:0
`define BMOC_TX_HOBS      3:2
`define BMOC_TX_ETSS      4
`define BMOC_TX_MPAF      10:5
`define BMOC_TX_BIFUNK    11
`define BMOC_TX_W         12
`define BMOC_TX_RST       12'h000

`endif

// file: bmoc_pkg.sv
package bmoc_pkg;
   // Origination phase of the head-of-bus octet sequence
   typedef enum logic [1:0] {
      BMOC_ORIG_T0 = 2'b01,
      BMOC_ORIG_T1 = 2'b10
   } bmoc_phase_type;

   // Head-of-bus status codes as carried on the bus
   typedef enum logic [1:0] {
      BMOC_HOB_NONE   = 2'b00,
      BMOC_HOB_STABLE = 2'b01,
      BMOC_HOB_WAIT   = 2'b10,
      BMOC_HOB_BAD    = 2'b11
   } bmoc_hob_type;
endpackage

// file: bmoc_vote_if.sv
`timescale 1ns/1ns
// One filtered field: a valid sample in, the majority vote out
interface bmoc_vote_if;
   logic smp_valid;
   logic smp;
   logic vote;
   modport src  (output smp_valid, output smp, input vote);
   modport filt (input smp_valid, input smp, output vote);
endinterface

// file: bmoc_vote_filter.sv
`timescale 1ns/1ns
module bmoc_vote_filter (
   input  wire logic   clk_sys,
   input  wire logic   arst_n,
   bmoc_vote_if.filt   vif
);
   import bmoc_pkg::*;

   logic [2:0] hist_reg;
   logic [1:0] cnt_reg;
   logic [2:0] hist_next;
   logic       vote_reg;

   // Shift in each valid sample, newest in bit 0
   assign hist_next = {hist_reg[1:0], vif.smp};

   // History of the last three valid samples
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         hist_reg <= 3'h0;
         cnt_reg  <= 2'h0;
      end else if (vif.smp_valid) begin
         hist_reg <= hist_next;
         if (cnt_reg != 2'h3) begin
            cnt_reg <= cnt_reg + 2'h1;
         end
      end
   end

   // Adopt a value once it has two of the last three samples
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         vote_reg <= 1'b0;
      end else if (vif.smp_valid) begin
         if (cnt_reg == 2'h0) begin
            vote_reg <= vote_reg;
         end else if (cnt_reg == 2'h1) begin
            if (hist_next[1] == hist_next[0]) begin
               vote_reg <= hist_next[0];
            end
         end else begin
            vote_reg <= (hist_next[0] & hist_next[1]) | (hist_next[0] & hist_next[2])
                        | (hist_next[1] & hist_next[2]);
         end
      end
   end

   assign vif.vote = vote_reg;
endmodule

// file: bmoc_codec_top.sv
`timescale 1ns/1ns
`include "bmoc_consts.svh"

// Notes on behaviour
// [R1] Type 0 octet: flag, 2-bit bus identity, 5-bit configuration field.
// [R2] Type 1 octet: flag, reserved zero bit, 6-bit page allocation field.
// [R3] Active head of bus originates every management octet on its bus.
// [R4] Head of bus alternates the type flag on successive originated octets.
// [R5] Downstream nodes pass the type flag through unchanged.
// [R6] Only the active head of bus writes the bus identity.
// [R7] Bus identity 01 is A, 10 is B, 00 unknown; 11 never sent.
// [R8] Configuration field: slot generator, head status, timing source subfields.
// [R9] Overwrite a configuration subfield only when this node owns the resource.
// [R10] Slot generator 00 means absent upstream, 11 means present.
// [R11] Slot generator node reads 01/10 as absent; others only relay them.
// [R12] Head status 01 stable, 10 waiting, 00 no active head.
// [R13] Head status 11 is not interpreted and is relayed unchanged.
// [R14] Timing source bit 0 absent upstream, 1 present upstream.
// [R15] Page field: reservation, counter modulus, counter control, two bits each.
// [R16] Reservation 00 free, 11 reserved, for the current page counter.
// [R17] Reservation 01/10 is error: free on bus A, reserved on bus B.
// [R18] Modulus carries page number mod 4, checked against local counter.
// [R19] Modulus is plain binary 0 to 3.
// [R20] Counter control 01 resets to 1; 10, 00, 11 increment.
// [R21] Filtered fields adopt the value seen twice in last three valid samples.
// [R22] Relayed subfields use the latest received value, not the filtered one.
// [R23] First octet after reset or activation carries type 0.
module bmoc_codec_top (
   input  wire logic                  clk_sys,
   input  wire logic                  arst_n,
   input  wire logic [3:0]            avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   output logic      [31:0]           avs_readdata,
   output logic                       avs_waitrequest,
   input  wire logic                  rx_valid,
   input  wire logic [7:0]            rx_octet,
   input  wire logic [1:0]            page_cnt_mod,
   output logic                       tx_valid,
   output logic      [7:0]            tx_octet,
   output logic                       dsg_present,
   output logic                       hob_stable,
   output logic                       hob_none,
   output logic                       ets_present,
   output logic                       bif_is_b,
   output logic                       pr_valid,
   output logic                       pr_reserved,
   output logic                       pcm_mismatch,
   output logic                       pcc_reset,
   output logic                       pcc_incr,
   output bmoc_pkg::bmoc_phase_type   orig_phase
);
   import bmoc_pkg::*;

   // Valid two-bit codes are the pairs 00 and 11
   function automatic logic pair_valid(input logic [1:0] code);
      pair_valid = (code[1] == code[0]);
   endfunction

   // Pick the local value for an owned subfield, else the received one
   function automatic logic [1:0] pick2(input logic own, input logic [1:0] loc, input logic [1:0] rcv);
      pick2 = own ? loc : rcv;
   endfunction

   logic [`BMOC_CTRL_W-1:0] ctrl_reg;
   logic [`BMOC_TX_W-1:0]   txcfg_reg;
   logic                    wait_reg;
   logic [31:0]             rdata_reg;
   logic [31:0]             rdata_next;
   logic                    acc_done;
   logic                    hob_act;
   logic                    hob_act_d_reg;
   bmoc_phase_type          phase_reg;
   logic                    tx_valid_reg;
   logic [7:0]              tx_octet_reg;
   logic [7:0]              tx_next;
   logic [1:0]              bif_gen;
   logic                    rx_t0;
   logic                    rx_t1;
   logic [1:0]              rx_dsgs;
   logic [1:0]              rx_hobs;
   logic [1:0]              rx_bif;
   logic [1:0]              rx_pr;
   logic                    hob_none_reg;
   logic                    pr_valid_reg;
   logic                    pr_res_reg;
   logic                    pcm_mis_reg;
   logic                    pcc_reset_reg;
   logic                    pcc_incr_reg;

   bmoc_vote_if dsg_vif ();
   bmoc_vote_if hob_vif ();
   bmoc_vote_if ets_vif ();
   bmoc_vote_if bif_vif ();

   assign hob_act  = ctrl_reg[`BMOC_CTRL_HOB];
   assign acc_done = !wait_reg && (avs_read || avs_write);
   assign rx_t0    = rx_valid && !rx_octet[`BMOC_TYPE_BIT];
   assign rx_t1    = rx_valid && rx_octet[`BMOC_TYPE_BIT];
   assign rx_dsgs  = rx_octet[`BMOC_DSGS];
   assign rx_hobs  = rx_octet[`BMOC_HOBS];
   assign rx_bif   = rx_octet[`BMOC_BIF];
   assign rx_pr    = rx_octet[`BMOC_PR];

   // Bus slave: one wait cycle, then a single answer cycle
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         wait_reg <= 1'b1;
      end else if ((avs_read || avs_write) && wait_reg) begin
         wait_reg <= 1'b0;
      end else begin
         wait_reg <= 1'b1;
      end
   end

   // Read data mux; unmapped offsets read as zero
   always_comb begin
      rdata_next = 32'h0000_0000;
      unique case (avs_address)
         `BMOC_OFS_CTRL:   rdata_next[`BMOC_CTRL_W-1:0] = ctrl_reg;
         `BMOC_OFS_TXCFG:  rdata_next[`BMOC_TX_W-1:0]   = txcfg_reg;
         `BMOC_OFS_STATUS: rdata_next[9:0] = {phase_reg, pcm_mis_reg, pr_res_reg, hob_none_reg,
                                              bif_vif.vote, ets_vif.vote, hob_vif.vote, dsg_vif.vote,
                                              hob_act_d_reg};
         default:          rdata_next = 32'h0000_0000;
      endcase
   end

   // Read data captured while waitrequest is still high
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rdata_reg <= 32'h0000_0000;
      end else if (avs_read && wait_reg) begin
         rdata_reg <= rdata_next;
      end
   end

   // Register writes take effect at the answering edge only
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg  <= `BMOC_CTRL_RST;
         txcfg_reg <= `BMOC_TX_RST;
      end else if (acc_done && avs_write) begin
         if (avs_address == `BMOC_OFS_CTRL) begin
            ctrl_reg <= avs_writedata[`BMOC_CTRL_W-1:0];
         end
         if (avs_address == `BMOC_OFS_TXCFG) begin
            txcfg_reg <= avs_writedata[`BMOC_TX_W-1:0];
         end
      end
   end

   // Bus identity generated by the head: never the spare code
   assign bif_gen = txcfg_reg[`BMOC_TX_BIFUNK] ? `BMOC_BIF_UNK :
                    (ctrl_reg[`BMOC_CTRL_BUSB] ? `BMOC_BIF_B : `BMOC_BIF_A); // R7 R6

   // Delayed head-active level, to see activation
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         hob_act_d_reg <= 1'b0;
      end else begin
         hob_act_d_reg <= hob_act;
      end
   end

   // Origination phase: type 0 first, then alternating
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         phase_reg <= BMOC_ORIG_T0; // R23
      end else if (!hob_act || !hob_act_d_reg) begin
         phase_reg <= BMOC_ORIG_T0; // R23
      end else if (rx_valid) begin
         unique case (phase_reg)
            BMOC_ORIG_T0: phase_reg <= BMOC_ORIG_T1; // R4
            BMOC_ORIG_T1: phase_reg <= BMOC_ORIG_T0; // R4
            default:      phase_reg <= BMOC_ORIG_T0;
         endcase
      end
   end

   // Outgoing octet: originated at the head, relayed elsewhere
   always_comb begin
      tx_next = rx_octet; // R5 R13
      if (hob_act && hob_act_d_reg) begin
         // Slot filled by the head; unowned type 0 subfields below still take incoming content
         if (phase_reg == BMOC_ORIG_T0) begin
            tx_next[`BMOC_TYPE_BIT] = 1'b0; // R3 R4 R1
            tx_next[`BMOC_BIF]      = bif_gen; // R6
         end else begin
            tx_next[`BMOC_TYPE_BIT] = 1'b1; // R4 R2
            tx_next[`BMOC_RSVD_BIT] = 1'b0; // R2
            tx_next[`BMOC_MPAF]     = txcfg_reg[`BMOC_TX_MPAF]; // R15 R19
         end
      end
      if (!tx_next[`BMOC_TYPE_BIT]) begin
         // Configuration subfields: owned ones local, others latest received
         tx_next[`BMOC_DSGS] = pick2(ctrl_reg[`BMOC_CTRL_OWNDSG], txcfg_reg[`BMOC_TX_DSGS], rx_dsgs); // R9 R22 R8
         tx_next[`BMOC_HOBS] = pick2(ctrl_reg[`BMOC_CTRL_OWNHOB], txcfg_reg[`BMOC_TX_HOBS], rx_hobs); // R9 R22
         tx_next[`BMOC_ETSS] = ctrl_reg[`BMOC_CTRL_OWNETS] ? txcfg_reg[`BMOC_TX_ETSS]
                                                            : rx_octet[`BMOC_ETSS]; // R9 R22
      end
   end

   // Transmit register, one cycle behind the received octet
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         tx_valid_reg <= 1'b0;
         tx_octet_reg <= 8'h00;
      end else begin
         tx_valid_reg <= rx_valid;
         if (rx_valid) begin
            tx_octet_reg <= tx_next;
         end
      end
   end

   // Filter samples; slot generator node treats 01/10 as absent
   assign dsg_vif.smp_valid = rx_t0 && (pair_valid(rx_dsgs) || ctrl_reg[`BMOC_CTRL_DSGN]); // R11 R21
   assign dsg_vif.smp       = (rx_dsgs == `BMOC_DSG_PRES); // R10
   assign hob_vif.smp_valid = rx_t0 && (rx_hobs == BMOC_HOB_STABLE || rx_hobs == BMOC_HOB_WAIT); // R12 R21
   assign hob_vif.smp       = (rx_hobs == BMOC_HOB_STABLE); // R12
   assign ets_vif.smp_valid = rx_t0; // R21
   assign ets_vif.smp       = rx_octet[`BMOC_ETSS]; // R14
   assign bif_vif.smp_valid = rx_t0 && (rx_bif == `BMOC_BIF_A || rx_bif == `BMOC_BIF_B); // R21
   assign bif_vif.smp       = (rx_bif == `BMOC_BIF_B);

   bmoc_vote_filter u_dsg_filt (.clk_sys(clk_sys), .arst_n(arst_n), .vif(dsg_vif.filt));
   bmoc_vote_filter u_hob_filt (.clk_sys(clk_sys), .arst_n(arst_n), .vif(hob_vif.filt));
   bmoc_vote_filter u_ets_filt (.clk_sys(clk_sys), .arst_n(arst_n), .vif(ets_vif.filt));
   bmoc_vote_filter u_bif_filt (.clk_sys(clk_sys), .arst_n(arst_n), .vif(bif_vif.filt));

   // No-active-head indication from the latest type 0 octet whose head status is not 11
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         hob_none_reg <= 1'b0;
      end else if (rx_t0 && rx_hobs != BMOC_HOB_BAD) begin
         hob_none_reg <= (rx_hobs == BMOC_HOB_NONE); // R12 R13
      end
   end

   // Page reservation and modulus check per type 1 octet
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pr_valid_reg <= 1'b0;
         pr_res_reg   <= 1'b0;
         pcm_mis_reg  <= 1'b0;
      end else begin
         pr_valid_reg <= rx_t1;
         if (rx_t1) begin
            if (pair_valid(rx_pr)) begin
               pr_res_reg <= (rx_pr == `BMOC_PR_RES); // R16
            end else begin
               pr_res_reg <= ctrl_reg[`BMOC_CTRL_BUSB]; // R17
            end
            pcm_mis_reg <= (rx_octet[`BMOC_PCM] != page_cnt_mod); // R18 R19
         end
      end
   end

   // Page counter control pulses
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pcc_reset_reg <= 1'b0;
         pcc_incr_reg  <= 1'b0;
      end else begin
         pcc_reset_reg <= rx_t1 && (rx_octet[`BMOC_PCC] == `BMOC_PCC_RESET); // R20
         pcc_incr_reg  <= rx_t1 && (rx_octet[`BMOC_PCC] != `BMOC_PCC_RESET); // R20
      end
   end

   assign avs_readdata    = rdata_reg;
   assign avs_waitrequest = wait_reg;
   assign tx_valid        = tx_valid_reg;
   assign tx_octet        = tx_octet_reg;
   assign dsg_present     = dsg_vif.vote;
   assign hob_stable      = hob_vif.vote;
   assign hob_none        = hob_none_reg;
   assign ets_present     = ets_vif.vote;
   assign bif_is_b        = bif_vif.vote;
   assign pr_valid        = pr_valid_reg;
   assign pr_reserved     = pr_res_reg;
   assign pcm_mismatch    = pcm_mis_reg;
   assign pcc_reset       = pcc_reset_reg;
   assign pcc_incr        = pcc_incr_reg;
   assign orig_phase      = phase_reg;

   // Originated octets alternate type
   type_alternate_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // R4
      (tx_valid && $past(hob_act && hob_act_d_reg))
      |-> tx_octet[`BMOC_TYPE_BIT] == ($past(phase_reg) == BMOC_ORIG_T1))
      else $error("originated type did not alternate");

   // Spare bus identity never originated by the head
   bif_spare_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // R7
      (tx_valid && !tx_octet[`BMOC_TYPE_BIT] && $past(hob_act && hob_act_d_reg))
      |-> tx_octet[`BMOC_BIF] != 2'h3)
      else $error("bus identity 11 generated");

   // Relayed type flag unchanged
   type_relay_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // R5
      $past(rx_valid && !hob_act) |-> tx_octet[`BMOC_TYPE_BIT] == $past(rx_octet[`BMOC_TYPE_BIT]))
      else $error("relayed type flag changed");

   // Reserved bit zero in originated type 1
   rsvd_zero_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // R2
      (tx_valid && tx_octet[`BMOC_TYPE_BIT] && $past(hob_act && hob_act_d_reg))
      |-> !tx_octet[`BMOC_RSVD_BIT])
      else $error("reserved bit set");

   // First originated octet after activation is type 0
   first_type0_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // R23
      (hob_act && !hob_act_d_reg) |=> orig_phase == BMOC_ORIG_T0)
      else $error("first originated octet not type 0");

   // Reservation error decodes by bus
   pr_error_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // R17
      (rx_t1 && !pair_valid(rx_pr)) |=> pr_reserved == $past(ctrl_reg[`BMOC_CTRL_BUSB]))
      else $error("reservation error decoded wrong");

   // Control decode: exactly one pulse per type 1 octet
   pcc_pulse_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // R20
      rx_t1 |=> (pcc_reset ^ pcc_incr) && (pcc_reset == ($past(rx_octet[`BMOC_PCC]) == 2'h1)))
      else $error("counter control decode wrong");

   // Unowned head status subfield relays the latest received value
   sncf_relay_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // R9
      (rx_t0 && !ctrl_reg[`BMOC_CTRL_OWNHOB] && !hob_act) |=> tx_octet[`BMOC_HOBS] == $past(rx_hobs))
      else $error("unowned head status rewritten");

   // Head status decode: 00 means none, 11 leaves the flag alone
   hob_none_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // R12 R13
      rx_t0 |=> hob_none == (($past(rx_hobs) == BMOC_HOB_BAD) ? $past(hob_none)
                                                              : ($past(rx_hobs) == BMOC_HOB_NONE)))
      else $error("head status decode wrong");

   // Valid reservation codes decode directly
   pr_code_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // R16
      (rx_t1 && pair_valid(rx_pr)) |=> pr_valid && (pr_reserved == ($past(rx_pr) == `BMOC_PR_RES)))
      else $error("reservation decode wrong");

   // Bus answer after exactly one wait cycle
   bus_answer_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer timing wrong");
endmodule

// file: bmoc_node_model.sv
`timescale 1ns/1ns
// Upstream neighbour: sends queued octets with a chosen gap after each
module bmoc_node_model (
   input  wire logic       clk_sys,
   output logic            rx_valid,
   output logic      [7:0] rx_octet,
   output logic      [1:0] page_cnt_mod
);
   logic [11:0] oq[$];
   logic [1:0]  gap_reg;
   logic [11:0] ent;

   // Type 0 octet: flag, bus identity, slot gen, head status, timing source
   function automatic logic [7:0] mk0(input logic [1:0] b, input logic [1:0] d, input logic [1:0] h, input logic e);
      return {1'b0, b, d, h, e};
   endfunction

   // Type 1 octet: flag, reserved bit held at zero, reservation, modulus, control
   function automatic logic [7:0] mk1(input logic [1:0] r, input logic [1:0] m, input logic [1:0] c);
      return {2'b10, r, m, c};
   endfunction

   task enq(input logic [11:0] e);
      oq.push_back(e);
   endtask

   initial begin
      rx_valid = 1'b0;
      rx_octet = 8'h00;
      page_cnt_mod = 2'h0;
      gap_reg = 2'h0;
   end

   // One slot per edge; idle slots show a toggling pattern, never stale data
   always @(posedge clk_sys) begin
      if (gap_reg != 2'h0) begin
         gap_reg <= gap_reg - 2'h1;
         rx_valid <= 1'b0;
         rx_octet <= ~rx_octet;
      end else if (oq.size() != 0) begin
         ent = oq.pop_front();
         rx_valid <= 1'b1;
         rx_octet <= ent[7:0];
         page_cnt_mod <= ent[9:8];
         gap_reg <= ent[11:10];
      end else begin
         rx_valid <= 1'b0;
         rx_octet <= ~rx_octet;
      end
   end
endmodule

// file: bmoc_codec_top_tb_top.sv
`timescale 1ns/1ns
`include "bmoc_consts.svh"
module bmoc_codec_top_tb_top;
   import bmoc_pkg::*;
   typedef struct {logic [7:0] oct; logic dec; logic [4:0] d;} bmoc_exp_type;
   logic           clk_sys = 1'b0;
   logic           arst_n = 1'b0;
   logic [3:0]     avs_address = 4'h0;
   logic           avs_read = 1'b0;
   logic           avs_write = 1'b0;
   logic [31:0]    avs_writedata = 32'h0;
   logic [31:0]    avs_readdata;
   logic           avs_waitrequest, rx_valid, tx_valid, dsg_present, hob_stable, hob_none, ets_present, bif_is_b;
   logic           pr_valid, pr_reserved, pcm_mismatch, pcc_reset, pcc_incr, bus_b;
   logic [7:0]     rx_octet, tx_octet;
   logic [1:0]     page_cnt_mod;
   bmoc_phase_type orig_phase;
   bmoc_exp_type   exp_q[$];
   logic [31:0]    rd_q[$];
   int             n_mismatch = 0;
   int             samples_checked = 0;
   int             cycles = 0;

   always #50 clk_sys = ~clk_sys;

   bmoc_node_model up (.clk_sys(clk_sys), .rx_valid(rx_valid), .rx_octet(rx_octet), .page_cnt_mod(page_cnt_mod));

   bmoc_codec_top DUT (.clk_sys(clk_sys), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid), .rx_octet(rx_octet), .page_cnt_mod(page_cnt_mod),
      .tx_valid(tx_valid), .tx_octet(tx_octet), .dsg_present(dsg_present), .hob_stable(hob_stable),
      .hob_none(hob_none), .ets_present(ets_present), .bif_is_b(bif_is_b), .pr_valid(pr_valid),
      .pr_reserved(pr_reserved), .pcm_mismatch(pcm_mismatch), .pcc_reset(pcc_reset), .pcc_incr(pcc_incr),
      .orig_phase(orig_phase));

   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task summarize();
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Bus cycles: request held until waitrequest is sampled low
   task bus_wr(input logic [3:0] a, input logic [31:0] d);
      avs_write <= 1'b1;
      avs_address <= a;
      avs_writedata <= d;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask

   task bus_rd(input logic [3:0] a, input logic [31:0] exp);
      rd_q.push_back(exp);
      avs_read <= 1'b1;
      avs_address <= a;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      avs_read <= 1'b0;
      @(posedge clk_sys);
   endtask

   // Expected decode pulses and levels: valid, reserved, mismatch, reset, incr
   function automatic logic [4:0] dec_of(input logic [7:0] o, input logic [1:0] pg);
      logic res;
      res = (o[5:4] == 2'h3) || (o[5:4] != 2'h0 && bus_b);
      if (!o[7])
         return 5'h00;
      return {1'b1, res, o[3:2] != pg, o[1:0] == 2'h1, o[1:0] != 2'h1};
   endfunction

   task push(input logic [7:0] o, input logic [7:0] x, input logic dec);
      logic [1:0]   pg;
      logic [1:0]   gp;
      bmoc_exp_type e;
      pg = 2'($urandom);
      gp = 2'($urandom_range(0, 2));
      e.oct = x;
      e.dec = dec;
      e.d = dec_of(o, pg);
      exp_q.push_back(e);
      up.enq({gp, pg, o});
   endtask

   task p0(input logic [1:0] b, input logic [1:0] d, input logic [1:0] h, input logic e);
      push(up.mk0(b, d, h, e), up.mk0(b, d, h, e), 1'b1);
   endtask

   task drain();
      while (exp_q.size() != 0) @(posedge clk_sys);
      repeat (3) @(posedge clk_sys);
   endtask

   task fchk(input logic [4:0] exp);
      drain();
      check({27'h0, dsg_present, hob_stable, hob_none, ets_present, bif_is_b}, {27'h0, exp});
   endtask

   // Head of bus: every slot replaced, type alternating from type 0
   task head_run(input logic [5:0] ctl, input logic [12:0] cfg, input logic [1:0] bif, input int n);
      bus_wr(`BMOC_OFS_TXCFG, {19'h0, cfg});
      bus_wr(`BMOC_OFS_CTRL, {26'h0, ctl});
      repeat (3) @(posedge clk_sys);
      for (int i = 0; i < n; i++)
         push(8'($urandom), (i % 2 == 0) ? {1'b0, bif, cfg[1:0], cfg[3:2], cfg[4]} : {2'b10, cfg[10:5]}, 1'b0);
      drain();
      check({30'h0, orig_phase}, (n % 2) ? {30'h0, BMOC_ORIG_T1} : {30'h0, BMOC_ORIG_T0});
   endtask

   // Output watcher: oldest note against each result
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         summarize();
      end
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
         check(avs_readdata, rd_q.pop_front());
      if (arst_n === 1'b1 && tx_valid === 1'b1) begin
         if (exp_q.size() == 0)
            check(32'h1, 32'h0);
         else begin
            check({24'h0, tx_octet}, {24'h0, exp_q[0].oct});
            if (exp_q[0].dec)
               check({27'h0, {pr_valid, pr_reserved, pcm_mismatch, pcc_reset, pcc_incr} & (exp_q[0].oct[7] ? 5'h1f : 5'h13)}, {27'h0, exp_q[0].d});
            void'(exp_q.pop_front());
         end
      end
   end

   initial begin
      logic [7:0] o;
      bus_b = 1'b0;
      void'($urandom(8));
      repeat (4) @(posedge clk_sys);
      arst_n <= 1'b1;
      @(posedge clk_sys);
      // Register reset values, access kinds, unmapped offset
      bus_rd(`BMOC_OFS_CTRL, 32'h0);
      bus_rd(`BMOC_OFS_TXCFG, 32'h0);
      bus_wr(`BMOC_OFS_CTRL, 32'hffff_fffe);
      bus_rd(`BMOC_OFS_CTRL, 32'h3e);
      bus_wr(`BMOC_OFS_TXCFG, 32'hffff_ffff);
      bus_rd(`BMOC_OFS_TXCFG, 32'hfff);
      bus_wr(`BMOC_OFS_CTRL, 32'h0);
      bus_wr(`BMOC_OFS_STATUS, 32'hffff_ffff);
      bus_wr(4'hc, 32'hffff_ffff);
      bus_rd(4'hc, 32'h0);
      bus_rd(`BMOC_OFS_STATUS, 32'h100);
      // Plain relay of random octets
      for (int i = 0; i < 16; i++) begin
         o = 8'($urandom);
         if (o[7])
            o[6] = 1'b0;
         push(o, o, 1'b1);
      end
      // Majority filter with invalid codes mixed in
      repeat (3) p0(2'h2, 2'h3, 2'h1, 1'b1);
      fchk(5'b11011);
      p0(2'h1, 2'h1, 2'h3, 1'b0);
      fchk(5'b11011);
      p0(2'h1, 2'h0, 2'h2, 1'b0);
      fchk(5'b11000);
      p0(2'h1, 2'h0, 2'h0, 1'b0);
      fchk(5'b01100);
      // Slot generator node counts invalid codes as absent
      bus_wr(`BMOC_OFS_CTRL, 32'h4);
      repeat (2) p0(2'h1, 2'h3, 2'h1, 1'b0);
      repeat (2) p0(2'h1, 2'h2, 2'h1, 1'b0);
      fchk(5'b01000);
      // Page field decode on bus A, then bus B
      for (int k = 0; k < 2; k++) begin
         for (int i = 0; i < 16; i++) begin
            o = up.mk1(2'(i >> 2), 2'($urandom), 2'(i));
            push(o, o, 1'b1);
         end
         drain();
         bus_wr(`BMOC_OFS_CTRL, {30'h0, 2'b10});
         bus_b = 1'b1;
         repeat (3) p0(2'h2, 2'h0, 2'h0, 1'b0);
      end
      drain();
      // Owned slot gen and timing source overwritten, head status relayed
      bus_wr(`BMOC_OFS_TXCFG, 32'h1b);
      bus_wr(`BMOC_OFS_CTRL, 32'h28);
      bus_b = 1'b0;
      for (int i = 0; i < 8; i++) begin
         o = 8'($urandom);
         if (o[7])
            o[6] = 1'b0;
         push(o, o[7] ? o : {o[7:5], 2'b11, o[2:1], 1'b1}, 1'b1);
      end
      drain();
      head_run(6'h39, 13'h0353, 2'h1, 5);
      // Reset in mid-run with the head active and phase at type 1
      arst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      check({30'h0, orig_phase}, {30'h0, BMOC_ORIG_T0});
      check({31'h0, tx_valid}, 32'h0);
      arst_n <= 1'b1;
      @(posedge clk_sys);
      head_run(6'h3b, 13'h02a6, 2'h2, 6);
      head_run(6'h3b, 13'h0b53, 2'h0, 4);
      summarize();
   end
endmodule
